// ==== logic/nsp_serdes.sv ====
// Purpose: NRZI transmitter and receiver with AXI4-Lite control
// Assumes: One bit per enabled aclk cycle; pins synchronous
// Notes:   Clock recovery is a free bit counter, no PLL
//
// What this block does
// - Capture transmit symbol on local clock rise
// - Transmitter off low forces line pair zero
// - Test mode: transmitter off becomes test clock
// - Loopback select low: loop output follows transmit stream even with line forced off; else forced zero
// - Test input selects test mode; normally low
// - Line pair carries serial NRZI stream
// - Loopback select low picks loop input pair outside test mode
// - Receive input decoded from NRZI to NRZ
// - Symbol outputs update on recovered clock fall
// - Symbol clock is bit clock over five
// - Signal detect low gates line, locks local
// - Signal detect output is resynchronised input
// - Receive test mode clocks from loop input
// - Symbol bit four is sent first
// - Loopback active ignores signal detect input
// - Signal detect low zeroes output register
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
module nsp_serdes (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      ce,
    input  wire logic [nsp_pkg::SYM_W-1:0] tx_symbol_in,
    output logic                           tx_symbol_ready,
    input  wire logic                      local_symbol_clock,
    input  wire logic                      transmitter_off_n,
    input  wire logic                      loopback_sel_n,
    input  wire logic                      test_mode,
    output nsp_pkg::nsp_pair_s             line_out_pair,
    output nsp_pkg::nsp_pair_s             loop_out_pair,
    input  wire nsp_pkg::nsp_pair_s        line_in_pair,
    input  wire nsp_pkg::nsp_pair_s        loop_in_pair,
    input  wire logic                      signal_detect_in,
    output logic                           signal_detect_out,
    output logic [nsp_pkg::SYM_W-1:0]      rx_symbol_out,
    output logic                           recovered_symbol_clock,
    input  wire logic [nsp_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [nsp_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);
    localparam int SW = nsp_pkg::SYM_W;

    function automatic logic [2:0] cnt_next(input logic [2:0] c);
        cnt_next = (c == nsp_pkg::BIT_CNT_LAST) ? 3'h0 : c + 3'h1;
    endfunction

    function automatic logic is_mapped(input logic [nsp_pkg::AXI_AW-1:0] a);
        is_mapped = (a == nsp_pkg::CTRL_OFFS) || (a == nsp_pkg::STAT_OFFS);
    endfunction

    // Pins used as clocks
    logic lsc_q, toff_q, lpin_q;
    logic lsc_rise, toff_rise, lpin_rise;

    always_comb begin
        lsc_rise  = local_symbol_clock & ~lsc_q;
        toff_rise = transmitter_off_n & ~toff_q;
        lpin_rise = loop_in_pair.p & ~lpin_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lsc_q  <= 1'b0;
            toff_q <= 1'b1; // Idle level: no false tick
            lpin_q <= 1'b0;
        end else if (ce) begin
            lsc_q  <= local_symbol_clock;
            toff_q <= transmitter_off_n;
            lpin_q <= loop_in_pair.p;
        end
    end

    // Register file
    logic [31:0]      ctrl_q, ctrl_d;
    nsp_pkg::nsp_wr_e wst_q, wst_d;
    logic             aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [nsp_pkg::AXI_AW-1:0] waddr_q, waddr_d;
    logic [31:0]      wdata_q, wdata_d;
    logic [3:0]       wstrb_q, wstrb_d;
    logic [1:0]       bresp_q, bresp_d;
    logic             rvalid_q, rvalid_d;
    logic [31:0]      rdata_q, rdata_d;
    logic [1:0]       rresp_q, rresp_d;
    logic [31:0]      status;
    logic             fifo_full, fifo_empty;

    always_comb begin
        status = '0;
        status[nsp_pkg::STAT_SD]    = signal_detect_out;
        status[nsp_pkg::STAT_FULL]  = fifo_full;
        status[nsp_pkg::STAT_EMPTY] = fifo_empty;
        status[nsp_pkg::STAT_TEST]  = test_mode;
        status[nsp_pkg::STAT_SYM_LSB +: SW] = rx_symbol_out;
    end

    always_comb begin
        s_axi_awready = (wst_q == nsp_pkg::WR_IDLE) && ~aw_got_q;
        s_axi_wready  = (wst_q == nsp_pkg::WR_IDLE) && ~w_got_q;
        s_axi_bvalid  = (wst_q == nsp_pkg::WR_RESP);
        s_axi_bresp   = bresp_q;
        s_axi_arready = ~rvalid_q;
        s_axi_rvalid  = rvalid_q;
        s_axi_rdata   = rdata_q;
        s_axi_rresp   = rresp_q;
        wst_d    = wst_q;
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        waddr_d  = waddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bresp_d  = bresp_q;
        ctrl_d   = ctrl_q;
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        unique case (wst_q)
            nsp_pkg::WR_IDLE: begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_got_d = 1'b1;
                    waddr_d  = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_got_d = 1'b1;
                    wdata_d = s_axi_wdata;
                    wstrb_d = s_axi_wstrb;
                end
                if (aw_got_q && w_got_q) begin
                    wst_d   = nsp_pkg::WR_RESP;
                    bresp_d = is_mapped(waddr_q) ? nsp_pkg::RESP_OKAY : nsp_pkg::RESP_SLVERR;
                    if (waddr_q == nsp_pkg::CTRL_OFFS) begin
                        for (int i = 0; i < 4; i++) begin
                            if (wstrb_q[i]) begin
                                ctrl_d[8*i +: 8] = wdata_q[8*i +: 8];
                            end
                        end
                    end
                end
            end
            nsp_pkg::WR_RESP: begin
                if (s_axi_bready) begin
                    wst_d    = nsp_pkg::WR_IDLE;
                    aw_got_d = 1'b0;
                    w_got_d  = 1'b0;
                end
            end
            default: wst_d = nsp_pkg::WR_IDLE;
        endcase
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end else if (s_axi_arvalid && ~rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = is_mapped(s_axi_araddr) ? nsp_pkg::RESP_OKAY : nsp_pkg::RESP_SLVERR;
            rdata_d  = (s_axi_araddr == nsp_pkg::CTRL_OFFS) ? ctrl_q :
                       (s_axi_araddr == nsp_pkg::STAT_OFFS) ? status : 32'h0000_0000;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q    <= nsp_pkg::WR_IDLE;
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            waddr_q  <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            bresp_q  <= nsp_pkg::RESP_OKAY;
            ctrl_q   <= nsp_pkg::CTRL_RESET;
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= nsp_pkg::RESP_OKAY;
        end else if (ce) begin
            wst_q    <= wst_d;
            aw_got_q <= aw_got_d;
            w_got_q  <= w_got_d;
            waddr_q  <= waddr_d;
            wdata_q  <= wdata_d;
            wstrb_q  <= wstrb_d;
            bresp_q  <= bresp_d;
            ctrl_q   <= ctrl_d;
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    // Transmit path
    logic          tx_pop, tx_avail;
    logic [SW-1:0] tx_head;

    nsp_fifo #(
        .W     (SW),
        .DEPTH (nsp_pkg::FIFO_DEPTH),
        .AW    (nsp_pkg::FIFO_AW)
    ) u_tx_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .in_valid  (lsc_rise),
        .in_ready  (tx_symbol_ready),
        .in_data   (tx_symbol_in),
        .out_valid (tx_avail),
        .out_ready (tx_pop),
        .out_data  (tx_head),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    logic [2:0]        tx_cnt_q, tx_cnt_d;
    logic [SW-1:0]     tx_sh_q, tx_sh_d;
    logic              tx_lvl_q, tx_lvl_d;
    logic              tx_tick, tx_bit, tx_off;
    nsp_pkg::nsp_pair_s line_d, loop_d;

    always_comb begin
        tx_tick  = test_mode ? toff_rise : 1'b1;
        tx_cnt_d = tx_cnt_q;
        tx_sh_d  = tx_sh_q;
        tx_lvl_d = tx_lvl_q;
        tx_pop   = 1'b0;
        tx_bit   = 1'b0;
        // Symbol clock restarts test counter
        if (test_mode && lsc_rise) begin
            tx_cnt_d = 3'h0;
        end else if (tx_tick) begin
            if (tx_cnt_q == 3'h0) begin
                // Underrun sends zeros: line holds level
                tx_pop  = tx_avail;
                tx_bit  = tx_avail ? tx_head[SW-1] : 1'b0;
                tx_sh_d = tx_avail ? {tx_head[SW-2:0], 1'b0} : '0;
            end else begin
                tx_bit  = tx_sh_q[SW-1];
                tx_sh_d = {tx_sh_q[SW-2:0], 1'b0};
            end
            tx_lvl_d = tx_lvl_q ^ tx_bit;
            tx_cnt_d = cnt_next(tx_cnt_q);
        end
        tx_off = ~transmitter_off_n | ctrl_q[nsp_pkg::CTRL_SOFT_OFF];
        line_d = '{p: tx_lvl_d, n: ~tx_lvl_d};
        if (!test_mode && tx_off) begin
            line_d = '{p: 1'b0, n: 1'b1};
        end
        loop_d = loopback_sel_n ? '{p: 1'b0, n: 1'b1} : '{p: tx_lvl_d, n: ~tx_lvl_d};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_cnt_q      <= 3'h0;
            tx_sh_q       <= '0;
            tx_lvl_q      <= 1'b0;
            line_out_pair <= '{p: 1'b0, n: 1'b1};
            loop_out_pair <= '{p: 1'b0, n: 1'b1};
        end else if (ce) begin
            tx_cnt_q      <= tx_cnt_d;
            tx_sh_q       <= tx_sh_d;
            tx_lvl_q      <= tx_lvl_d;
            line_out_pair <= line_d;
            loop_out_pair <= loop_d;
        end
    end

    // Receive path
    logic          sd_m_q, sd_s_q;
    logic          sd_eff, rx_src, rx_tick, rx_nrz;
    logic [2:0]    rx_cnt_q, rx_cnt_d;
    logic          rx_prev_q, rx_prev_d;
    logic [SW-1:0] rx_sh_q, rx_sh_d;
    logic [SW-1:0] rx_word_q, rx_word_d;
    logic [SW-1:0] rx_out_d;
    logic          rsc_d;

    always_comb begin
        signal_detect_out = sd_s_q;
        sd_eff = ~loopback_sel_n | signal_detect_in;
        // Loop pair clocks test mode; data from line
        if (!loopback_sel_n && !test_mode) begin
            rx_src = loop_in_pair.p;
        end else begin
            rx_src = line_in_pair.p & sd_eff;
        end
        rx_tick   = test_mode ? lpin_rise : 1'b1;
        rx_nrz    = rx_src ^ rx_prev_q;
        rx_cnt_d  = rx_cnt_q;
        rx_prev_d = rx_prev_q;
        rx_sh_d   = rx_sh_q;
        rx_word_d = rx_word_q;
        rx_out_d  = rx_symbol_out;
        if (!sd_eff && lsc_rise) begin
            rx_cnt_d = 3'h0;
        end else if (rx_tick) begin
            rx_prev_d = rx_src;
            rx_sh_d   = {rx_sh_q[SW-2:0], rx_nrz};
            rx_cnt_d  = cnt_next(rx_cnt_q);
            if (rx_cnt_q == nsp_pkg::BIT_CNT_LAST) begin
                rx_word_d = {rx_sh_q[SW-2:0], rx_nrz};
            end
        end
        rsc_d = (rx_cnt_d < nsp_pkg::RSC_LOW_CNT);
        if (recovered_symbol_clock && !rsc_d) begin
            rx_out_d = rx_word_q;
        end
        if (!sd_eff) begin
            rx_out_d = '0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sd_m_q                 <= 1'b0;
            sd_s_q                 <= 1'b0;
            rx_cnt_q               <= 3'h0;
            rx_prev_q              <= 1'b0;
            rx_sh_q                <= '0;
            rx_word_q              <= '0;
            rx_symbol_out          <= '0;
            recovered_symbol_clock <= 1'b0;
        end else if (ce) begin
            sd_m_q                 <= signal_detect_in;
            sd_s_q                 <= sd_m_q;
            rx_cnt_q               <= rx_cnt_d;
            rx_prev_q              <= rx_prev_d;
            rx_sh_q                <= rx_sh_d;
            rx_word_q              <= rx_word_d;
            rx_symbol_out          <= rx_out_d;
            recovered_symbol_clock <= rsc_d;
        end
    end
endmodule

// ==== include/nsp_pkg.sv ====
// Purpose: Shared constants and types for the NRZI symbol serdes pair
// Assumes: One bit per enabled aclk cycle
// Notes:   Word-aligned AXI4-Lite register map
package nsp_pkg;

    localparam int          SYM_W         = 5;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          FIFO_AW       = 4;
    localparam logic [2:0]  BIT_CNT_LAST  = 3'h4;
    localparam logic [2:0]  RSC_LOW_CNT   = 3'h3;
    localparam int          CLK_PERIOD_NS = 10;

    localparam int          AXI_AW        = 4;
    localparam logic [3:0]  CTRL_OFFS     = 4'h0;
    localparam logic [3:0]  STAT_OFFS     = 4'h4;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam int          CTRL_SOFT_OFF = 0;
    localparam int          STAT_SD       = 0;
    localparam int          STAT_FULL     = 1;
    localparam int          STAT_EMPTY    = 2;
    localparam int          STAT_TEST     = 3;
    localparam int          STAT_SYM_LSB  = 4;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic p;
        logic n;
    } nsp_pair_s;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } nsp_wr_e;

endpackage

// ==== logic/nsp_fifo.sv ====
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Extra pointer bit tells full from empty
`timescale 1ns/1ns
module nsp_fifo #(
    parameter int W     = 5,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic              full,
    output logic              empty
);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  wr_d;
    logic [AW:0]  rd_q;
    logic [AW:0]  rd_d;
    logic         push;
    logic         pop;

    always_comb begin
        empty     = (wr_q == rd_q);
        full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
        in_ready  = ~full;
        out_valid = ~empty;
        out_data  = mem_q[rd_q[AW-1:0]];
        push      = ce && in_valid && ~full;
        pop       = ce && out_ready && ~empty;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // Storage unreset: never read before written
    always_ff @(posedge aclk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==== tb/nsp_serdes_props.sv ====
// Purpose: Port checker for nsp_serdes
// Assumes: ce held high while timing is judged
// Notes:   Bound to every nsp_serdes instance
`timescale 1ns/1ns
module nsp_serdes_props (
    input wire logic                       aclk,
    input wire logic                       aresetn,
    input wire logic                       ce,
    input wire logic                       transmitter_off_n,
    input wire logic                       loopback_sel_n,
    input wire logic                       test_mode,
    input wire nsp_pkg::nsp_pair_s         line_out_pair,
    input wire nsp_pkg::nsp_pair_s         loop_out_pair,
    input wire logic                       signal_detect_in,
    input wire logic                       signal_detect_out,
    input wire logic [nsp_pkg::SYM_W-1:0]  rx_symbol_out,
    input wire logic                       recovered_symbol_clock,
    input wire logic                       s_axi_awvalid,
    input wire logic                       s_axi_awready,
    input wire logic                       s_axi_wvalid,
    input wire logic                       s_axi_wready,
    input wire logic                       s_axi_bvalid,
    input wire logic                       s_axi_arvalid,
    input wire logic                       s_axi_arready,
    input wire logic                       s_axi_rvalid
);
    logic [2:0] up_q, up_d;
    logic [4:0] sdl_q, sdl_d;
    logic       run_ok;
    logic       rsc;
    assign rsc = recovered_symbol_clock;
    // Counter runs free only on qualified input
    assign run_ok = ce && !test_mode && (!loopback_sel_n || signal_detect_in);
    always_comb begin
        up_d  = (up_q == 3'h7) ? up_q : up_q + 3'h1;
        sdl_d = 5'h00;
        if (loopback_sel_n && !signal_detect_in && !test_mode) begin
            sdl_d = (sdl_q == 5'h1f) ? sdl_q : sdl_q + 5'h01;
        end
    end
    always_ff @(posedge aclk) begin
        up_q  <= aresetn ? up_d : 3'h0;
        sdl_q <= aresetn ? sdl_d : 5'h00;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_off_zero;
        up_q > 3'h1 && !$past(transmitter_off_n) && !$past(test_mode) |-> line_out_pair == 2'b01;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("line pair not forced");
    property p_loop_off;
        up_q > 3'h1 && $past(loopback_sel_n) |-> loop_out_pair == 2'b01;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("loop pair not forced");
    property p_loop_same;
        up_q > 3'h1 && !$past(loopback_sel_n) && line_out_pair != 2'b01
            |-> loop_out_pair == line_out_pair;
    endproperty
    a_loop_same: assert property (p_loop_same) else $error("loop pair differs");
    property p_diff;
        line_out_pair.n == !line_out_pair.p && loop_out_pair.n == !loop_out_pair.p;
    endproperty
    a_diff: assert property (p_diff) else $error("pair not complementary");
    property p_div5;
        (rsc && !$past(rsc) && run_ok && up_q > 3'h2) ##1 run_ok[*5]
            |-> rsc && $past(rsc, 5) && $past(rsc, 4) && $past(rsc, 3)
                && !$past(rsc, 2) && !$past(rsc);
    endproperty
    a_div5: assert property (p_div5) else $error("symbol clock not divided by five");
    property p_rx_fall;
        up_q > 3'h3 && run_ok && $past(run_ok) && $past(run_ok, 2) && $past(run_ok, 3)
            && $changed(rx_symbol_out)
            |-> (!rsc && $past(rsc)) || (!$past(rsc) && $past(rsc, 2));
    endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("symbol out moved off clock fall");
    property p_sd_zero;
        sdl_q > 5'h13 |-> rx_symbol_out == 5'h00;
    endproperty
    a_sd_zero: assert property (p_sd_zero) else $error("symbol out not cleared");
    property p_sd_sync;
        up_q > 3'h2 |-> signal_detect_out == $past(signal_detect_in, 2);
    endproperty
    a_sd_sync: assert property (p_sd_sync) else $error("detect out wrong");
    property p_b_time;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_b_time: assert property (p_b_time) else $error("write response late");
    property p_r_time;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_time: assert property (p_r_time) else $error("read response late");
    property p_busy;
        (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
    endproperty
    a_busy: assert property (p_busy) else $error("request taken while busy");
endmodule
bind nsp_serdes nsp_serdes_props u_props (.aclk, .aresetn, .ce, .transmitter_off_n,
    .loopback_sel_n, .test_mode, .line_out_pair, .loop_out_pair, .signal_detect_in,
    .signal_detect_out, .rx_symbol_out, .recovered_symbol_clock, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid);

// ==== tb/nsp_phy_model.sv ====
// Purpose: Symbol-side controller model feeding the transmitter
// Assumes: Five aclk cycles make one symbol time
// Notes:   Pause stops the symbol clock to drain the buffer
`timescale 1ns/1ns
module nsp_phy_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       pause,
    input  wire logic [4:0] sym_in,
    output logic            took,
    output logic            local_symbol_clock,
    output logic [4:0]      tx_symbol_in
);
    logic [2:0] cnt_q, cnt_d;
    logic [4:0] sym_q, sym_d;
    assign took = !pause && cnt_q == 3'h4;
    assign local_symbol_clock = cnt_q == 3'h1 || cnt_q == 3'h2;
    assign tx_symbol_in = sym_q;
    always_comb begin
        cnt_d = pause ? cnt_q : (took ? 3'h0 : cnt_q + 3'h1);
        sym_d = took ? sym_in : sym_q;
    end
    always_ff @(posedge aclk) begin
        cnt_q <= aresetn ? cnt_d : 3'h0;
        sym_q <= aresetn ? sym_d : 5'h00;
    end
endmodule

// ==== tb/nsp_serdes_test.sv ====
// Purpose: Self-checking bench for nsp_serdes
// Assumes: ce tied high; loop pair wired straight back
// Notes:   Receive words are unframed, so any rotation is accepted
`timescale 1ns/1ns
module nsp_serdes_test;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, pause = 1'b0, took;
    logic transmitter_off_n = 1'b1, loopback_sel_n = 1'b1, test_mode = 1'b0;
    logic signal_detect_in = 1'b0, signal_detect_out, recovered_symbol_clock;
    logic tx_symbol_ready, local_symbol_clock, chk_line = 1'b0, drv_line = 1'b0;
    logic [4:0] tx_symbol_in, rx_symbol_out, sym_in = 5'h00, fill_sym = 5'h00, acc;
    nsp_pkg::nsp_pair_s line_out_pair, loop_out_pair, line_in_pair = 2'b01;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, prev_p = 1'b0, aligned = 1'b0, seen, ctl;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [4:0] burst_q[$], exp_q[$];
    int seed = 32'hf82e, error_cnt = 0, total_checks = 0, nb = 0, ybit = 0, n;
    localparam logic [4:0] SYM_X = 5'h0b, SYM_Y = 5'h13;
    nsp_phy_model phy (.aclk, .aresetn, .pause, .sym_in, .took, .local_symbol_clock,
        .tx_symbol_in);
    nsp_serdes uut (.aclk, .aresetn, .ce, .tx_symbol_in, .tx_symbol_ready, .local_symbol_clock,
        .transmitter_off_n, .loopback_sel_n, .test_mode, .line_out_pair, .loop_out_pair,
        .line_in_pair, .loop_in_pair(loop_out_pair), .signal_detect_in, .signal_detect_out,
        .rx_symbol_out, .recovered_symbol_clock, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    always #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic is_rot(input logic [4:0] v, s);
        logic [9:0] dd;
        dd = {s, s};
        is_rot = 1'b0;
        for (int i = 0; i < 5; i++) is_rot |= (dd[i +: 5] === v);
    endfunction
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] wd, input logic [3:0] ws);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_wstrb <= ws;
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        fork
            begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // Partner feed, line driver, serial decoder
    always @(posedge aclk) begin
        if (took && chk_line) exp_q.push_back(sym_in);
        if (took) sym_in <= (burst_q.size() > 0) ? burst_q.pop_front() : fill_sym;
        if (drv_line && SYM_Y[4 - ybit]) line_in_pair <= '{!line_in_pair.p, line_in_pair.p};
        if (!drv_line) line_in_pair <= 2'($random(seed)) ^ 2'b01;
        ybit <= (ybit == 4) ? 0 : ybit + 1;
        prev_p <= line_out_pair.p;
        if (chk_line && (aligned || (line_out_pair.p ^ prev_p))) begin
            while (!aligned && exp_q.size() > 0 && exp_q[0] == 5'h00) void'(exp_q.pop_front());
            aligned = 1'b1;
            acc = {acc[3:0], line_out_pair.p ^ prev_p};
            nb++;
            if (nb == 5) begin
                chk(acc, (exp_q.size() > 0) ? exp_q.pop_front() : 5'h00);
                nb = 0;
            end
        end
    end
    initial begin
        #50000;
        error_cnt++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(nsp_pkg::CTRL_OFFS);
        chk(d, nsp_pkg::CTRL_RESET);
        axi_rd(4'h8);
        chk({d[29:0], r}, {30'h0, nsp_pkg::RESP_SLVERR});
        axi_wr(4'hc, 32'h1, 4'hf);
        chk(r, nsp_pkg::RESP_SLVERR);
        chk_line <= 1'b1;
        for (int i = 0; i < 20; i++) burst_q.push_back(5'($random(seed)) | {i == 0, 4'h0});
        repeat (200) @(posedge aclk);
        chk_line <= 1'b0;
        chk(aligned, 1'b1);
        axi_wr(nsp_pkg::CTRL_OFFS, 32'h1, 4'h1);
        repeat (3) @(posedge aclk);
        chk(line_out_pair, 2'b01);
        axi_wr(nsp_pkg::CTRL_OFFS, 32'h0, 4'h1);
        transmitter_off_n <= 1'b0;
        repeat (3) @(posedge aclk);
        chk(line_out_pair, 2'b01);
        transmitter_off_n <= 1'b1;
        fill_sym <= SYM_X;
        loopback_sel_n <= 1'b0;
        repeat (80) @(posedge aclk);
        chk(is_rot(rx_symbol_out, SYM_X), 1'b1);
        chk(signal_detect_out, 1'b0);
        loopback_sel_n <= 1'b1;
        signal_detect_in <= 1'b1;
        drv_line <= 1'b1;
        repeat (60) @(posedge aclk);
        chk(is_rot(rx_symbol_out, SYM_Y), 1'b1);
        axi_rd(nsp_pkg::STAT_OFFS);
        chk({is_rot(d[8:4], SYM_Y), d[0], signal_detect_out}, 3'b111);
        signal_detect_in <= 1'b0;
        drv_line <= 1'b0;
        repeat (40) @(posedge aclk);
        chk(rx_symbol_out, 5'h00);
        test_mode <= 1'b1;
        n = 0;
        do begin @(posedge aclk); n++; end while (tx_symbol_ready && n < 200);
        axi_rd(nsp_pkg::STAT_OFFS);
        chk(d[3:1], 3'b101);
        pause <= 1'b1;
        seen = 1'b0;
        ctl = line_out_pair.p;
        repeat (100) begin
            @(posedge aclk) transmitter_off_n <= 1'b0;
            @(posedge aclk) transmitter_off_n <= 1'b1;
            seen |= line_out_pair.p ^ ctl;
        end
        chk(seen, 1'b1);
        axi_rd(nsp_pkg::STAT_OFFS);
        chk(d[2], 1'b1);
        test_mode <= 1'b0;
        pause <= 1'b0;
        ctl = 1'b0;
        repeat (8) begin
            d = $random(seed);
            n = $random(seed);
            if (n[0]) ctl = d[0];
            axi_wr(nsp_pkg::CTRL_OFFS, d, 4'(n));
            axi_rd(nsp_pkg::CTRL_OFFS);
            chk({d[0], r}, {ctl, nsp_pkg::RESP_OKAY});
        end
        close_out();
    end
endmodule
